// [design/twa_params.svh]
// twa_params.svh: bus port timing and codes
// assumes a 40 MHz clock; fixed bit timing
`ifndef TWA_PARAMS_SVH
`define TWA_PARAMS_SVH
`define TWA_CLK_NS    25
`define TWA_T_LOW_NS  5000
`define TWA_T_HIGH_NS 4000
`define TWA_LOW_CYC   ((`TWA_T_LOW_NS + `TWA_CLK_NS - 1) / `TWA_CLK_NS)
`define TWA_HIGH_CYC  ((`TWA_T_HIGH_NS + `TWA_CLK_NS - 1) / `TWA_CLK_NS)
`define TWA_LOW_HALF  (`TWA_LOW_CYC / 2)
`define TWA_ACK_BIT   4'h8
`define TWA_BIT_END   4'h9
`define TWA_ERR_BIT   4'h2
`define TWA_GC_ADDR   7'h00
`define TWA_RSVD_HI   4'hF
`define TWA_GC_READ   8'h01
`endif

// [design/twa_pkg.sv]
// twa_pkg: shared types
// assumes numbers come from twa_params.svh
package twa_pkg;
   typedef enum logic [1:0] {
      TWA_CMD_START, TWA_CMD_WRITE, TWA_CMD_READ, TWA_CMD_STOP
   } twa_cmd_t;
   typedef enum logic [3:0] {
      M_IDLE, M_START, M_HOLD, M_LOW, M_HIGH_WAIT, M_HIGH,
      M_RS_LOW, M_RS_HIGH, M_SP_LOW, M_SP_HIGH
   } twa_mst_t;
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_RX, S_TX, S_PASS
   } twa_slv_t;
endpackage

// [design/twa_line_if.sv]
// twa_line_if: sampled bus line levels and line events
// assumes one driver, readers on the same clock
`timescale 1ns/1ps
interface twa_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic busy;
   modport det (output scl, sda, scl_rise, scl_fall, start_det, stop_det, busy);
   modport mon (input  scl, sda, scl_rise, scl_fall, start_det, stop_det, busy);
endinterface // twa_line_if

// [design/twa_sync.sv]
// twa_sync: two-stage synchroniser for one asynchronous level
// assumes d is asynchronous
`timescale 1ns/1ps
module twa_sync (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_r <= 1'b1;
         q      <= 1'b1;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // twa_sync

// [design/twa_cond.sv]
// twa_cond: line edge, start, stop and busy detection
// assumes synchronised inputs
`timescale 1ns/1ps
module twa_cond (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic scl_s,
   input  wire logic sda_s,
   twa_line_if.det   line
);
   logic scl_r;
   logic sda_r;
   logic busy_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end else begin
         scl_r <= scl_s;
         sda_r <= sda_s;
      end
   end

   // busy from any start up to the next stop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
      end else if (line.start_det) begin
         busy_r <= 1'b1;
      end else if (line.stop_det) begin
         busy_r <= 1'b0;
      end
   end

   assign line.scl       = scl_r;
   assign line.sda       = sda_r;
   assign line.scl_rise  = scl_s & ~scl_r;
   assign line.scl_fall  = ~scl_s & scl_r;
   assign line.start_det = scl_s & scl_r & sda_r & ~sda_s;
   assign line.stop_det  = scl_s & scl_r & ~sda_r & sda_s;
   assign line.busy      = busy_r;
endmodule // twa_cond

// [design/twa_top.sv]
// twa_top: two-wire bus port, master with arbitration plus slave engine
// assumes open-drain pads; pins are async
//
// Operation
// - start and stop only while clock high
// - bus busy start to stop; no seizing
// - owner may repeat start before stop
// - address packet: seven bits, direction, acknowledge
// - direction one reads, zero writes
// - addressed slave pulls data low on ninth
// - address nack then stop or restart
// - address byte sent most significant first
// - general call accepted with write, then data
// - addresses 1111xxx reserved, never matched
// - data packet: eight bits msb first, acknowledge
// - receiver acks each byte, nacks last
// - only master clocks and frames the bus
// - transfer needs address and data; no empty
// - slave may stretch clock low; master waits
// - master restarts counts on seen clock edges
// - released high read low loses arbitration
// - on loss stop and act as slave
// - after loss release data line high
// - arbitration continues through data bytes too
// - lines driven open-drain only, wired-AND
// - data stable while clock high
`timescale 1ns/1ps
`include "twa_params.svh"
module twa_top import twa_pkg::*; (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       cmd_valid,
   input  twa_cmd_t        cmd_code,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_ack,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_ack,
   output logic            rsp_error,
   input  wire logic [6:0] own_addr,
   input  wire logic       gc_enable,
   input  wire logic       slave_ack_en,
   input  wire logic       slave_hold,
   input  wire logic [7:0] slave_tx_data,
   output logic            slave_match,
   output logic            slave_dir_read,
   output logic            slave_gen_call,
   output logic            slave_tx_load,
   output logic            slave_rx_valid,
   output logic [7:0]      slave_rx_data,
   output logic            bus_busy,
   output logic            arb_lost,
   output logic            bus_error
);
   localparam logic [7:0] LOW_CYC  = 8'(`TWA_LOW_CYC);
   localparam logic [7:0] HIGH_CYC = 8'(`TWA_HIGH_CYC);
   localparam logic [7:0] LOW_HALF = 8'(`TWA_LOW_HALF);

   twa_line_if line ();
   logic     scl_s;
   logic     sda_s;
   twa_mst_t m_state_r;
   logic [7:0] cnt_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic     m_scl_low_r;
   logic     m_sda_low_r;
   logic     is_read_r;
   logic     ack_out_r;
   logic     rx_ack_r;
   logic     first_r;
   logic     pkt_r;
   logic     addr_nack_r;
   logic     addr_rd_r;
   twa_slv_t s_state_r;
   logic [3:0] sbit_r;
   logic [7:0] ssh_r;
   logic [7:0] tx_r;
   logic     s_sda_low_r;
   logic     s_stretch_r;
   logic     s_mack_r;
   logic     own_hit;
   logic     gc_hit;
   logic     drive_bit;

   // ----------------------------------------------------------------
   // line sampling
   // ----------------------------------------------------------------
   twa_sync u_sync_scl (
      .clock (clock),
      .nrst  (nrst),
      .d     (scl_in),
      .q     (scl_s)
   );
   twa_sync u_sync_sda (
      .clock (clock),
      .nrst  (nrst),
      .d     (sda_in),
      .q     (sda_s)
   );
   twa_cond u_cond (
      .clock (clock),
      .nrst  (nrst),
      .scl_s (scl_s),
      .sda_s (sda_s),
      .line  (line)
   );

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   // pads only ever pull low; a release lets the pull-up win
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;
   assign scl_oe   = m_scl_low_r | s_stretch_r;
   assign sda_oe   = m_sda_low_r | s_sda_low_r;
   assign bus_busy = line.busy;

   // start waits for an idle bus; other commands are also taken in idle, then refused
   assign cmd_ready = (m_state_r == M_IDLE && !(cmd_code == TWA_CMD_START && line.busy))
                    || m_state_r == M_HOLD;

   // this master owns the data line level for the bit in flight
   assign drive_bit = (bit_r == `TWA_ACK_BIT) ? is_read_r : !is_read_r;

   // ----------------------------------------------------------------
   // master engine
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         m_state_r   <= M_IDLE;
         cnt_r       <= 8'h00;
         bit_r       <= 4'h0;
         sh_r        <= 8'h00;
         m_scl_low_r <= 1'b0;
         m_sda_low_r <= 1'b0;
         is_read_r   <= 1'b0;
         ack_out_r   <= 1'b0;
         rx_ack_r    <= 1'b0;
         first_r     <= 1'b0;
         pkt_r       <= 1'b0;
         addr_nack_r <= 1'b0;
         addr_rd_r   <= 1'b0;
         rsp_valid   <= 1'b0;
         rsp_data    <= 8'h00;
         rsp_ack     <= 1'b0;
         rsp_error   <= 1'b0;
         arb_lost    <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         arb_lost  <= 1'b0;
         case (m_state_r)
            M_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  if (cmd_code == TWA_CMD_START) begin
                     m_sda_low_r <= 1'b1;
                     cnt_r       <= HIGH_CYC;
                     m_state_r   <= M_START;
                  end else begin
                     rsp_valid <= 1'b1;
                     rsp_error <= 1'b1;
                  end
               end
            end
            M_START: begin
               if (cnt_r == 8'h00) begin
                  m_scl_low_r <= 1'b1;
                  first_r     <= 1'b1;
                  pkt_r       <= 1'b0;
                  addr_nack_r <= 1'b0;
                  rsp_valid   <= 1'b1;
                  rsp_error   <= 1'b0;
                  m_state_r   <= M_HOLD;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_HOLD: begin
               if (cmd_valid) begin
                  case (cmd_code)
                     TWA_CMD_START: begin
                        cnt_r     <= LOW_CYC;
                        m_state_r <= M_RS_LOW;
                     end
                     TWA_CMD_STOP: begin
                        if (pkt_r || addr_nack_r) begin
                           cnt_r     <= LOW_CYC;
                           m_state_r <= M_SP_LOW;
                        end else begin
                           rsp_valid <= 1'b1;
                           rsp_error <= 1'b1;
                        end
                     end
                     TWA_CMD_WRITE: begin
                        // general call with read is refused, it would clash
                        if (addr_nack_r || (!first_r && addr_rd_r)
                            || (first_r && cmd_data == `TWA_GC_READ)) begin
                           rsp_valid <= 1'b1;
                           rsp_error <= 1'b1;
                        end else begin
                           sh_r      <= cmd_data;
                           is_read_r <= 1'b0;
                           bit_r     <= 4'h0;
                           cnt_r     <= LOW_CYC;
                           m_state_r <= M_LOW;
                        end
                     end
                     default: begin
                        if (first_r || addr_nack_r || !addr_rd_r) begin
                           rsp_valid <= 1'b1;
                           rsp_error <= 1'b1;
                        end else begin
                           sh_r      <= 8'h00;
                           is_read_r <= 1'b1;
                           ack_out_r <= cmd_ack;
                           bit_r     <= 4'h0;
                           cnt_r     <= LOW_CYC;
                           m_state_r <= M_LOW;
                        end
                     end
                  endcase
               end
            end
            M_LOW: begin
               // data moves mid-low, well clear of both clock edges
               if (cnt_r == LOW_HALF) begin
                  if (bit_r == `TWA_ACK_BIT) begin
                     m_sda_low_r <= is_read_r & ack_out_r;
                  end else begin
                     m_sda_low_r <= !is_read_r & !sh_r[7];
                  end
               end
               if (cnt_r == 8'h00) begin
                  m_scl_low_r <= 1'b0;
                  m_state_r   <= M_HIGH_WAIT;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_HIGH_WAIT: begin
               // a stretching slave or slower master keeps us here
               if (line.scl_rise) begin
                  if (drive_bit && !m_sda_low_r && !line.sda) begin
                     m_scl_low_r <= 1'b0;
                     m_sda_low_r <= 1'b0;
                     arb_lost    <= 1'b1;
                     m_state_r   <= M_IDLE;
                  end else begin
                     if (bit_r == `TWA_ACK_BIT) begin
                        rx_ack_r <= !line.sda;
                     end else begin
                        sh_r <= {sh_r[6:0], line.sda};
                     end
                     cnt_r     <= HIGH_CYC;
                     m_state_r <= M_HIGH;
                  end
               end
            end
            M_HIGH: begin
               // a faster master ending high early cuts our count short
               if (line.scl_fall || cnt_r == 8'h00) begin
                  m_scl_low_r <= 1'b1;
                  if (bit_r == `TWA_ACK_BIT) begin
                     rsp_valid <= 1'b1;
                     rsp_data  <= sh_r;
                     rsp_ack   <= rx_ack_r;
                     rsp_error <= 1'b0;
                     if (first_r) begin
                        addr_nack_r <= !rx_ack_r;
                        addr_rd_r   <= sh_r[0];
                     end else begin
                        pkt_r <= 1'b1;
                     end
                     first_r   <= 1'b0;
                     m_state_r <= M_HOLD;
                  end else begin
                     bit_r     <= bit_r + 4'h1;
                     cnt_r     <= LOW_CYC;
                     m_state_r <= M_LOW;
                  end
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_RS_LOW: begin
               if (cnt_r == LOW_HALF) begin
                  m_sda_low_r <= 1'b0;
               end
               if (cnt_r == 8'h00) begin
                  m_scl_low_r <= 1'b0;
                  cnt_r       <= HIGH_CYC;
                  m_state_r   <= M_RS_HIGH;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_RS_HIGH: begin
               if (!line.scl) begin
                  cnt_r <= HIGH_CYC;
               end else if (cnt_r == 8'h00) begin
                  m_sda_low_r <= 1'b1;
                  cnt_r       <= HIGH_CYC;
                  m_state_r   <= M_START;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_SP_LOW: begin
               if (cnt_r == LOW_HALF) begin
                  m_sda_low_r <= 1'b1;
               end
               if (cnt_r == 8'h00) begin
                  m_scl_low_r <= 1'b0;
                  cnt_r       <= HIGH_CYC;
                  m_state_r   <= M_SP_HIGH;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            default: begin
               if (!line.scl) begin
                  cnt_r <= HIGH_CYC;
               end else if (cnt_r == 8'h00) begin
                  m_sda_low_r <= 1'b0;
                  rsp_valid   <= 1'b1;
                  rsp_error   <= 1'b0;
                  m_state_r   <= M_IDLE;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // slave engine
   // ----------------------------------------------------------------
   assign own_hit = ssh_r[7:1] == own_addr && own_addr[6:3] != `TWA_RSVD_HI;
   assign gc_hit  = gc_enable && ssh_r[7:1] == `TWA_GC_ADDR && !ssh_r[0];

   // the slave keeps shifting under our own master, so a lost
   // arbitration still leaves the full address to compare
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_state_r      <= S_IDLE;
         sbit_r         <= 4'h0;
         ssh_r          <= 8'h00;
         tx_r           <= 8'h00;
         s_sda_low_r    <= 1'b0;
         s_mack_r       <= 1'b0;
         slave_match    <= 1'b0;
         slave_dir_read <= 1'b0;
         slave_gen_call <= 1'b0;
         slave_tx_load  <= 1'b0;
         slave_rx_valid <= 1'b0;
         slave_rx_data  <= 8'h00;
      end else begin
         slave_match    <= 1'b0;
         slave_tx_load  <= 1'b0;
         slave_rx_valid <= 1'b0;
         if (line.stop_det) begin
            s_state_r   <= S_IDLE;
            s_sda_low_r <= 1'b0;
         end else if (line.start_det) begin
            s_state_r   <= S_ADDR;
            sbit_r      <= 4'h0;
            s_sda_low_r <= 1'b0;
         end else if (s_state_r != S_IDLE) begin
            if (line.scl_rise && sbit_r != `TWA_BIT_END) begin
               sbit_r <= sbit_r + 4'h1;
               if (sbit_r == `TWA_ACK_BIT) begin
                  s_mack_r <= !line.sda;
               end else begin
                  ssh_r <= {ssh_r[6:0], line.sda};
               end
            end
            if (line.scl_fall) begin
               if (sbit_r == `TWA_ACK_BIT) begin
                  case (s_state_r)
                     S_ADDR: begin
                        if ((own_hit || gc_hit) && slave_ack_en
                            && m_state_r == M_IDLE) begin
                           s_sda_low_r    <= 1'b1;
                           slave_match    <= 1'b1;
                           slave_dir_read <= ssh_r[0];
                           slave_gen_call <= gc_hit;
                           s_state_r      <= ssh_r[0] ? S_TX : S_RX;
                        end else begin
                           s_state_r <= S_PASS;
                        end
                     end
                     S_RX: begin
                        slave_rx_valid <= 1'b1;
                        slave_rx_data  <= ssh_r;
                        s_sda_low_r    <= slave_ack_en;
                     end
                     default: begin
                        s_sda_low_r <= 1'b0;
                     end
                  endcase
               end else if (sbit_r == `TWA_BIT_END) begin
                  sbit_r <= 4'h0;
                  if (s_state_r == S_TX && s_mack_r) begin
                     tx_r          <= slave_tx_data;
                     slave_tx_load <= 1'b1;
                     s_sda_low_r   <= !slave_tx_data[7];
                  end else begin
                     s_sda_low_r <= 1'b0;
                     if (s_state_r == S_TX) begin
                        s_state_r <= S_PASS;
                     end
                  end
               end else if (s_state_r == S_TX) begin
                  s_sda_low_r <= !tx_r[3'(4'h7 - sbit_r)];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // clock stretching and bus error
   // ----------------------------------------------------------------
   // stretch only grabs a line that is already low, never shortens high
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_stretch_r <= 1'b0;
      end else if (!slave_hold || s_state_r == S_IDLE || s_state_r == S_PASS) begin
         s_stretch_r <= 1'b0;
      end else if (line.scl_fall) begin
         s_stretch_r <= 1'b1;
      end
   end

   // start or stop after the second bit of a packet is misplaced
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus_error <= 1'b0;
      end else begin
         bus_error <= s_state_r != S_IDLE
                   && ((line.start_det || line.stop_det) && sbit_r >= `TWA_ERR_BIT
                       || line.stop_det && s_state_r == S_ADDR);
      end
   end
endmodule // twa_top

// [testbench/twa_assertions.sv]
// twa_assertions: pin checks, bound below
// assumes pins see the wired-AND level
`timescale 1ns/1ps
module twa_assertions import twa_pkg::*; (
   input wire logic       clock,
   input wire logic       nrst,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       scl_out,
   input wire logic       sda_out,
   input wire logic       scl_oe,
   input wire logic       sda_oe,
   input wire logic       cmd_valid,
   input twa_cmd_t        cmd_code,
   input wire logic       cmd_ready,
   input wire logic       rsp_valid,
   input wire logic       rsp_error,
   input wire logic [6:0] own_addr,
   input wire logic       slave_match,
   input wire logic       slave_gen_call,
   input wire logic       bus_busy,
   input wire logic       arb_lost
);
   // ----
   // pin clock high time; cleared by low clock or start
   // ----
   logic [8:0] hi_r;
   logic       sda_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hi_r  <= 9'h000;
         sda_r <= 1'b1;
      end else begin
         sda_r <= sda_in;
         hi_r  <= (!scl_in || (sda_r && !sda_in)) ? 9'h000 : hi_r + {8'h00, hi_r != 9'h1FF};
      end
   end
   chk_lines_open: assert property (!scl_out && !sda_out)
      else $error("pin value not low");
   chk_idle_refuse: assert property (cmd_valid && cmd_ready && !bus_busy &&
      cmd_code != TWA_CMD_START |=> rsp_valid && rsp_error) else $error("idle command taken");
   chk_busy_start: assert property ($rose(bus_busy) |-> scl_in)
      else $error("busy without clock high");
   chk_busy_stop: assert property ($fell(bus_busy) |-> scl_in && sda_in)
      else $error("idle without stop");
   chk_high_period: assert property ($rose(scl_oe) && hi_r != 9'h000 |->
      hi_r >= 9'h096 && hi_r <= 9'h0AF) else $error("clock high time wrong");
   chk_lost_release: assert property (arb_lost |-> ##[0:1] (!scl_oe && !sda_oe))
      else $error("lines held after loss");
   chk_lost_quiet: assert property (arb_lost |=> !rsp_valid [*8])
      else $error("response after loss");
   chk_lost_pulse: assert property (arb_lost |=> !arb_lost)
      else $error("loss event too long");
   chk_no_reserved: assert property (slave_match |-> slave_gen_call || own_addr[6:3] != 4'hF)
      else $error("reserved address matched");
endmodule // twa_assertions

bind twa_top twa_assertions i_chk (.clock, .nrst, .scl_in, .sda_in, .scl_out, .sda_out,
   .scl_oe, .sda_oe, .cmd_valid, .cmd_code, .cmd_ready, .rsp_valid, .rsp_error, .own_addr,
   .slave_match, .slave_gen_call, .bus_busy, .arb_lost);

// [testbench/twa_bus_model.sv]
// twa_bus_model: slave model on the shared lines
// assumes lines resolved outside
`timescale 1ns/1ps
module twa_bus_model #(parameter logic [6:0] ADDR = 7'h2A) (
   input  wire logic       clock,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       stretch,
   input  wire logic       jam,
   input  wire logic [7:0] tx_byte,
   output logic            scl_oe,
   output logic            sda_oe,
   output logic [7:0]      rx_byte
);
   // ----
   // bit engine
   // ----
   logic       scl_q = 1'b1, sda_q = 1'b1, drv = 1'b0, sel = 1'b0, rd = 1'b0, adr = 1'b0;
   logic [3:0] n = 4'h0;
   logic [7:0] sh = 8'h00, tx = 8'h00;
   int         st = 0;
   assign sda_oe = drv | jam;
   always @(posedge clock) begin
      scl_q  <= scl;
      sda_q  <= sda;
      st     <= (st > 0) ? st - 1 : 0;
      scl_oe <= st > 1;
      if (scl && scl_q && sda_q && !sda) begin
         n   <= 4'h0;
         adr <= 1'b1;
         sel <= 1'b0;
         drv <= 1'b0;
      end else if (scl && !scl_q) begin
         sh <= {sh[6:0], sda};
         n  <= n + 4'h1;
      end else if (!scl && scl_q) begin // data moves only while clock low
         if (stretch) st <= 300;
         if (n == 4'h8) begin
            if (adr) begin
               sel <= sh[7:1] == ADDR;
               rd  <= sh[0];
            end else if (sel && !rd) rx_byte <= sh;
            drv <= adr ? (sh[7:1] == ADDR) : (sel && !rd);
         end else if (n == 4'h9) begin
            n   <= 4'h0;
            adr <= 1'b0;
            tx  <= tx_byte;
            drv <= sel && rd && !sh[0] && !tx_byte[7]; // master nack releases only the first bit of the next byte
         end else if (sel && rd && !adr) drv <= !tx[3'h7 - n[2:0]];
      end
   end
endmodule // twa_bus_model

// [testbench/two_wire_bus_protocol_arbiter_tb_top.sv]
// bench top: device as master against a slave model
// assumes design, model and checker compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module two_wire_bus_protocol_arbiter_tb_top import twa_pkg::*;;
   localparam logic [6:0] ADDR = 7'h2A;
   logic       clock, nrst, cmd_valid, cmd_ack, jam, stretch, lost;
   logic       scl_oe, sda_oe, m_scl_oe, m_sda_oe, cmd_ready, rsp_valid, rsp_ack, rsp_error;
   logic       bus_busy, arb_lost;
   twa_cmd_t   cmd_code;
   logic [7:0] cmd_data, tx_byte, rx_byte, rsp_data, b;
   logic [6:0] own_addr;
   int         num_errors, check_count;
   wire        scl = !(scl_oe | m_scl_oe);
   wire        sda = !(sda_oe | m_sda_oe);
   twa_top i_dut (.clock, .nrst, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(),
      .sda_oe, .cmd_valid, .cmd_code, .cmd_data, .cmd_ack, .cmd_ready, .rsp_valid, .rsp_data,
      .rsp_ack, .rsp_error, .own_addr, .gc_enable(1'b1), .slave_ack_en(1'b1), .slave_hold(1'b0),
      .slave_tx_data(tx_byte), .slave_match(), .slave_dir_read(), .slave_gen_call(),
      .slave_tx_load(), .slave_rx_valid(), .slave_rx_data(), .bus_busy, .arb_lost, .bus_error());
   twa_bus_model #(.ADDR(ADDR)) i_far (.clock, .scl, .sda, .stretch, .jam, .tx_byte,
      .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte);
   // ----
   // tasks
   // ----
   function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic r);
      return {a, r};
   endfunction
   task automatic cmd(input twa_cmd_t c, input logic [7:0] d, input logic a);
      int k;
      k = 0;
      @(negedge clock);
      cmd_code  = c;
      cmd_data  = d;
      cmd_ack   = a;
      cmd_valid = 1'b1;
      #1;
      while (cmd_ready !== 1'b1 && k < 40000) begin
         @(negedge clock);
         #1;
         k++;
      end
      @(negedge clock);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && arb_lost !== 1'b1 && k < 40000) begin
         @(negedge clock);
         k++;
      end
      lost = arb_lost;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      #(90000 * 25);
      num_errors++;
      summarize();
   end
   // ----
   // scenarios
   // ----
   initial begin
      {nrst, cmd_valid, cmd_ack, jam, stretch, lost} = '0;
      cmd_code    = TWA_CMD_START;
      cmd_data    = 8'h00;
      num_errors  = 0;
      check_count = 0;
      void'($urandom(32'hEC3AB11B));
      own_addr = {4'hF, 3'($urandom)};
      tx_byte  = 8'($urandom);
      repeat (6) @(negedge clock);
      nrst = 1'b1;
      cmd(TWA_CMD_WRITE, 8'h00, 1'b0);  `CHK(rsp_error, 1'b1)
      cmd(TWA_CMD_START, 8'h00, 1'b0);  `CHK(bus_busy, 1'b1)
      cmd(TWA_CMD_STOP, 8'h00, 1'b0);   `CHK(rsp_error, 1'b1)
      cmd(TWA_CMD_WRITE, 8'h01, 1'b0);  `CHK(rsp_error, 1'b1)
      cmd(TWA_CMD_WRITE, addr_byte(ADDR, 1'b0), 1'b0); `CHK(rsp_ack, 1'b1)
      for (int i = 0; i < 3; i++) begin
         b       = 8'($urandom);
         stretch = 1'($urandom);
         cmd(TWA_CMD_WRITE, b, 1'b0);   `CHK(rsp_ack, 1'b1)
         `CHK(rx_byte, b)
      end
      stretch = 1'b0;
      cmd(TWA_CMD_START, 8'h00, 1'b0);  `CHK(bus_busy, 1'b1)
      cmd(TWA_CMD_WRITE, addr_byte(ADDR, 1'b1), 1'b0); `CHK(rsp_ack, 1'b1)
      cmd(TWA_CMD_READ, 8'h00, 1'b1);   `CHK(rsp_data, tx_byte)
      cmd(TWA_CMD_READ, 8'h00, 1'b0);   `CHK(rsp_data, tx_byte)
      cmd(TWA_CMD_START, 8'h00, 1'b0);
      cmd(TWA_CMD_WRITE, addr_byte(own_addr, 1'b0), 1'b0); `CHK(rsp_ack, 1'b0)
      cmd(TWA_CMD_WRITE, b, 1'b0);      `CHK(rsp_error, 1'b1)
      cmd(TWA_CMD_STOP, 8'h00, 1'b0);   `CHK(rsp_error, 1'b0)
      repeat (20) @(negedge clock);
      `CHK(bus_busy, 1'b0)
      cmd(TWA_CMD_START, 8'h00, 1'b0);
      jam = 1'b1;
      cmd(TWA_CMD_WRITE, 8'hFF, 1'b0);  `CHK(lost, 1'b1)
      @(negedge clock);
      `CHK(sda_oe, 1'b0)
      jam = 1'b0;
      repeat (20) @(negedge clock);
      `CHK(bus_busy, 1'b0)
      summarize();
   end
endmodule // two_wire_bus_protocol_arbiter_tb_top
